//--- common/vic_cfg.svh
// Constants of the vectored interrupt controller.
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH

// Source indexes; the natural priority number is the index plus one.
`define VIC_SRC_EXT0 0
`define VIC_SRC_TMR0 1
`define VIC_SRC_EXT1 2
`define VIC_SRC_TMR1 3
`define VIC_SRC_UART 4
`define VIC_SRC_TMR2 5
`define VIC_SRC_EXT2 6
`define VIC_SRC_EXT3 7
`define VIC_SRC_SPI 8
`define VIC_SRC_WAKE 9
`define VIC_SRC_SUPPLY 10

// Counts.
`define VIC_NUM_SRC 11
`define VIC_NUM_LEVELS 4
`define VIC_NUM_EXT 4

// Vector of source n is base plus n times step (SPI lands on 0043H).
`define VIC_VEC_BASE 16'h0003
`define VIC_VEC_STEP 16'h0008

// Bit positions in the primary enable register.
`define VIC_GATE_BIT 7
`define VIC_PRIMARY_SRC_BITS 6

// Bit positions in the extended enable register.
`define VIC_XEN_SPI 0
`define VIC_XEN_WAKE 1
`define VIC_XEN_SUPPLY 2

// Sources able to wake the device from power-down.
`define VIC_WAKE_MASK 11'h6C5

// Reset values.
`define VIC_RST_INSVC 4'h0
`define VIC_RST_VECTOR 16'h0000
`define VIC_RST_PIN_N 4'hF

`endif

//--- common/vic_pkg.sv
// Types shared by the vectored interrupt controller files.
`default_nettype none
package vic_pkg;
  typedef logic [1:0] vic_level_t;
  typedef logic [3:0] vic_src_t;
  typedef logic [15:0] vic_vec_t;
  typedef logic [10:0] vic_req_t;
  typedef logic [3:0] vic_insvc_t;
endpackage : vic_pkg
`default_nettype wire

//--- rtl/vic_prio_pick.sv
// Priority resolver: highest programmed level, then lowest source index.
`timescale 1ns/1ns
`default_nettype none
`include "vic_cfg.svh"
module vic_prio_pick (
  // Requests and their programmed levels
  input wire vic_pkg::vic_req_t req,
  input wire vic_pkg::vic_req_t lvl_low,
  input wire vic_pkg::vic_req_t lvl_high,
  // Winner
  output logic found,
  output vic_pkg::vic_src_t win_idx,
  output vic_pkg::vic_level_t win_lvl
);

  // Scanning from the highest index down with >= lets a lower index
  // overwrite an equal level, so ties go to the lower natural number.
  always_comb begin
    vic_pkg::vic_level_t lvl;
    lvl = 2'h0;
    found = 1'b0;
    win_idx = 4'h0;
    win_lvl = 2'h0;
    for (int i = `VIC_NUM_SRC - 1; i >= 0; i--) begin
      lvl = {lvl_high[i], lvl_low[i]};
      if (req[i] && (!found || lvl >= win_lvl)) begin
        found = 1'b1;
        win_idx = 4'(i);
        win_lvl = lvl;
      end
    end
  end

endmodule : vic_prio_pick
`default_nettype wire

//--- rtl/vic_top.sv
// Vectored interrupt controller: flags, priority, hardware call, service.
`timescale 1ns/1ns
`default_nettype none
`include "vic_cfg.svh"

// Notes on behaviour
// - Software may write the edge-mode pin flags and the timer 0 and 1 flags, raising interrupts itself.
// - Each source has its own enable; bit 7 gates all of them.
// - An enabled source other than supply drop requests whenever its flag reads one.
// - Serial peripheral: OR of three flags, 0043H, number 9, no wake.
// - Wake timer: overflow flag, 004BH, number 10, wakes power-down.
// - Supply drop: its flag, 0053H, number 11, wakes power-down.
// - Edge pins clear on vectoring; level pins follow inverted pin.
// - Timer 0 and 1 flags clear on vectoring; timer 2 never.
// - Flags are sampled, polled and resolved every machine cycle.
// - No call while equal or higher priority is in service.
// - Call only in the last machine cycle of an instruction.
// - No call on enable or priority writes, or on service return.
// - Blocked requests are not remembered; each poll starts afresh.
// - The call pushes the program counter only, then loads the vector.
// - Service return pops the counter and ends the active service.
// - A plain subroutine return leaves the service state untouched.
// - A level pin still low after return requests again.
// - Supply drop requests only with reset option zero and enabled.
module vic_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // External interrupt pins, active low, and trigger modes
  input wire logic [3:0] ext_pin_n,
  input wire logic [3:0] ext_edge_mode,
  // Timer overflow events, one-cycle pulses
  input wire logic timer_zero_overflow_set,
  input wire logic timer_one_overflow_set,
  // Software writes to the flags held here
  input wire logic [3:0] ext_flag_wr_en,
  input wire logic [3:0] ext_flag_wr_data,
  input wire logic [1:0] timer_flag_wr_en,
  input wire logic [1:0] timer_flag_wr_data,
  // Flags held in the peripherals
  input wire logic uart_receive_complete_flag,
  input wire logic uart_send_complete_flag,
  input wire logic timer_two_overflow_flag,
  input wire logic timer_two_ext_flag,
  input wire logic serial_periph_done_flag,
  input wire logic serial_periph_fault_flag,
  input wire logic serial_periph_overrun_flag,
  input wire logic wake_timer_overflow_flag,
  input wire logic supply_drop_flag,
  input wire logic supply_drop_reset_option,
  // Enable registers
  input wire logic [7:0] primary_irq_enable_reg,
  input wire logic [2:0] extended_irq_enable_reg,
  input wire logic [1:0] ext_hi_irq_enable,
  // Priority registers
  input wire logic [5:0] primary_prio_low_reg,
  input wire logic [5:0] primary_prio_high_reg,
  input wire logic [2:0] extended_prio_low_reg,
  input wire logic [2:0] extended_prio_high_reg,
  input wire logic [1:0] ext_hi_prio_low,
  input wire logic [1:0] ext_hi_prio_high,
  // Instruction status from the core
  input wire logic instr_last_cycle,
  input wire logic instr_writes_irq_cfg,
  input wire logic instr_is_return_from_service,
  // Call request to the core
  output logic hardware_long_call,
  output vic_pkg::vic_vec_t call_vector,
  output vic_pkg::vic_src_t call_source,
  // Status
  output vic_pkg::vic_insvc_t in_service,
  output logic [3:0] ext_pin_request_flag,
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic wake_request,
  output logic irq_request_pending
);

  // Vector address of a source.
  function automatic vic_pkg::vic_vec_t vec_of(input vic_pkg::vic_src_t s);
    vec_of = `VIC_VEC_BASE + 16'(s) * `VIC_VEC_STEP;
  endfunction : vec_of

  // True when nothing at this level or above is being serviced.
  function automatic logic level_free(input vic_pkg::vic_level_t lvl,
                                      input vic_pkg::vic_insvc_t isv);
    level_free = ((isv >> lvl) == 4'h0);
  endfunction : level_free

  // Service state with its highest level retired.
  function automatic vic_pkg::vic_insvc_t retire_top(
      input vic_pkg::vic_insvc_t isv);
    vic_pkg::vic_insvc_t r;
    logic done;
    r = isv;
    done = 1'b0;
    for (int i = `VIC_NUM_LEVELS - 1; i >= 0; i--) begin
      if (r[i] && !done) begin
        r[i] = 1'b0;
        done = 1'b1;
      end
    end
    retire_top = r;
  endfunction : retire_top

  // Flag update where a hardware set beats any clear in the same cycle.
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic clr);
    flag_next = set | (cur & ~clr);
  endfunction : flag_next

  // Pin levels of the previous machine cycle, for falling-edge detection.
  logic [3:0] pin_prev_n;

  // Source positions of the external pins in the request vector.
  wire [3:0] ext_src_idx [4];
  assign ext_src_idx[0] = 4'(`VIC_SRC_EXT0);
  assign ext_src_idx[1] = 4'(`VIC_SRC_EXT1);
  assign ext_src_idx[2] = 4'(`VIC_SRC_EXT2);
  assign ext_src_idx[3] = 4'(`VIC_SRC_EXT3);

  // Flag assembly per source.
  wire serial_periph_any;
  wire supply_drop_live;
  wire uart_any;
  wire timer_two_any;
  vic_pkg::vic_req_t flag_vec;

  assign serial_periph_any = serial_periph_done_flag |
                             serial_periph_fault_flag |
                             serial_periph_overrun_flag;
  assign supply_drop_live = supply_drop_flag &
                            ~supply_drop_reset_option;
  // Completion flags are only read here; software clears them.
  assign uart_any = uart_receive_complete_flag |
                    uart_send_complete_flag;
  // Timer 2 flags are owned and cleared outside the controller.
  assign timer_two_any = timer_two_overflow_flag | timer_two_ext_flag;

  assign flag_vec[`VIC_SRC_EXT0] = ext_pin_request_flag[0];
  assign flag_vec[`VIC_SRC_TMR0] = timer_zero_overflow_flag;
  assign flag_vec[`VIC_SRC_EXT1] = ext_pin_request_flag[1];
  assign flag_vec[`VIC_SRC_TMR1] = timer_one_overflow_flag;
  assign flag_vec[`VIC_SRC_UART] = uart_any;
  assign flag_vec[`VIC_SRC_TMR2] = timer_two_any;
  assign flag_vec[`VIC_SRC_EXT2] = ext_pin_request_flag[2];
  assign flag_vec[`VIC_SRC_EXT3] = ext_pin_request_flag[3];
  assign flag_vec[`VIC_SRC_SPI] = serial_periph_any;
  assign flag_vec[`VIC_SRC_WAKE] = wake_timer_overflow_flag;
  assign flag_vec[`VIC_SRC_SUPPLY] = supply_drop_live;

  // Enables per source.
  wire global_irq_gate;
  vic_pkg::vic_req_t enable_vec;

  assign global_irq_gate = primary_irq_enable_reg[`VIC_GATE_BIT];
  assign enable_vec = {
    extended_irq_enable_reg[`VIC_XEN_SUPPLY],
    extended_irq_enable_reg[`VIC_XEN_WAKE],
    extended_irq_enable_reg[`VIC_XEN_SPI],
    ext_hi_irq_enable,
    primary_irq_enable_reg[`VIC_PRIMARY_SRC_BITS-1:0]
  };

  // A flag at one requests, however it got there; nothing is latched.
  vic_pkg::vic_req_t req_vec;
  assign req_vec = flag_vec & enable_vec &
                   {`VIC_NUM_SRC{global_irq_gate}};

  // Programmed levels per source.
  vic_pkg::vic_req_t lvl_low_vec;
  vic_pkg::vic_req_t lvl_high_vec;
  assign lvl_low_vec = {extended_prio_low_reg, ext_hi_prio_low,
                        primary_prio_low_reg};
  assign lvl_high_vec = {extended_prio_high_reg, ext_hi_prio_high,
                         primary_prio_high_reg};

  // Priority resolution within the same machine cycle as the sample.
  logic win_found;
  vic_pkg::vic_src_t win_idx;
  vic_pkg::vic_level_t win_lvl;

  vic_prio_pick u_pick (
    .req(req_vec),
    .lvl_low(lvl_low_vec),
    .lvl_high(lvl_high_vec),
    .found(win_found),
    .win_idx(win_idx),
    .win_lvl(win_lvl)
  );

  // Call conditions.
  wire can_preempt;
  wire at_boundary;
  wire not_blocked;
  wire take_call;

  assign can_preempt = level_free(win_lvl, in_service);
  assign at_boundary = instr_last_cycle;
  assign not_blocked = ~instr_writes_irq_cfg &
                       ~instr_is_return_from_service;
  // Every condition is looked at afresh on each edge; a refused poll
  // leaves nothing behind, so a flag that drops meanwhile is lost.
  // That is the intended behaviour, not a race to be fixed.
  assign take_call = win_found & can_preempt & at_boundary & not_blocked;

  // Flags cleared by vectoring: edge-mode pins and timers 0 and 1.
  logic [3:0] ext_vec_clr;
  wire tmr0_vec_clr;
  wire tmr1_vec_clr;

  always_comb begin
    for (int i = 0; i < `VIC_NUM_EXT; i++) begin
      ext_vec_clr[i] = take_call & ext_edge_mode[i] &
                       (win_idx == ext_src_idx[i]);
    end
  end
  assign tmr0_vec_clr = take_call &
                        (win_idx == 4'(`VIC_SRC_TMR0));
  assign tmr1_vec_clr = take_call &
                        (win_idx == 4'(`VIC_SRC_TMR1));

  // Next values of the external pin flags.
  wire [3:0] ext_fall;
  logic [3:0] next_ext_flag;

  // The pin history resets to the idle high level, so a pin already held
  // low when reset ends is taken as a fresh falling edge.
  assign ext_fall = pin_prev_n & ~ext_pin_n;

  always_comb begin
    for (int i = 0; i < `VIC_NUM_EXT; i++) begin
      if (ext_edge_mode[i]) begin
        next_ext_flag[i] = flag_next(ext_pin_request_flag[i],
                             ext_fall[i] |
                             (ext_flag_wr_en[i] & ext_flag_wr_data[i]),
                             ext_vec_clr[i] |
                             (ext_flag_wr_en[i] &
                              ~ext_flag_wr_data[i]));
      end else begin
        // Level mode ignores software and re-requests while low.
        next_ext_flag[i] = ~ext_pin_n[i];
      end
    end
  end

  // Next values of the timer flags.
  wire next_tmr0_flag;
  wire next_tmr1_flag;

  assign next_tmr0_flag = flag_next(timer_zero_overflow_flag,
                            timer_zero_overflow_set |
                            (timer_flag_wr_en[0] & timer_flag_wr_data[0]),
                            tmr0_vec_clr |
                            (timer_flag_wr_en[0] &
                             ~timer_flag_wr_data[0]));
  assign next_tmr1_flag = flag_next(timer_one_overflow_flag,
                            timer_one_overflow_set |
                            (timer_flag_wr_en[1] & timer_flag_wr_data[1]),
                            tmr1_vec_clr |
                            (timer_flag_wr_en[1] &
                             ~timer_flag_wr_data[1]));

  // Next service state. A plain return is invisible here, so only the
  // service return retires a level; a call and that return never coincide.
  vic_pkg::vic_insvc_t next_in_service;

  always_comb begin
    next_in_service = in_service;
    if (take_call) begin
      next_in_service[win_lvl] = 1'b1;
    end else if (instr_is_return_from_service) begin
      next_in_service = retire_top(in_service);
    end
  end

  // Power-down wake: only the capable sources count, so SPI never wakes.
  wire next_wake;
  assign next_wake = |(req_vec & `VIC_WAKE_MASK);

  // Pin history and external pin flags.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_prev_n <= `VIC_RST_PIN_N;
      ext_pin_request_flag <= 4'h0;
    end else begin
      pin_prev_n <= ext_pin_n;
      ext_pin_request_flag <= next_ext_flag;
    end
  end

  // Timer overflow flags.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag <= 1'b0;
    end else begin
      timer_zero_overflow_flag <= next_tmr0_flag;
      timer_one_overflow_flag <= next_tmr1_flag;
    end
  end

  // Call request toward the core. The core pushes only the program
  // counter; the status word is the service routine's own business.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hardware_long_call <= 1'b0;
      call_vector <= `VIC_RST_VECTOR;
      call_source <= 4'h0;
    end else begin
      hardware_long_call <= take_call;
      if (take_call) begin
        call_vector <= vec_of(win_idx);
        call_source <= win_idx;
      end
    end
  end

  // Service levels change on the same edge as the call pulse, so a
  // back-to-back request at the same level is already refused.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in_service <= `VIC_RST_INSVC;
    end else begin
      in_service <= next_in_service;
    end
  end

  // Status toward the power manager and core.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wake_request <= 1'b0;
      irq_request_pending <= 1'b0;
    end else begin
      wake_request <= next_wake;
      // Pending lags the poll by one cycle; it is a status bit only and
      // never feeds back into the call decision.
      irq_request_pending <= win_found;
    end
  end

endmodule : vic_top
`default_nettype wire

//--- tb/vic_core_model.sv
// Behavioural core model: call stack depth and service return strobes.
`timescale 1ns/1ns
`default_nettype none
module vic_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Calls from the controller
  input wire logic hardware_long_call,
  input wire vic_pkg::vic_vec_t call_vector,
  // Return commands from the bench
  input wire logic ret_req,
  input wire logic plain_ret,
  // Towards the controller and the bench
  output logic instr_is_return_from_service,
  output logic [3:0] depth,
  output var vic_pkg::vic_vec_t pc
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      depth <= 4'h0;
      pc <= 16'h0000;
      instr_is_return_from_service <= 1'b0;
    end else begin
      // A plain return pops the stack but never tells the controller.
      instr_is_return_from_service <= ret_req;
      if (hardware_long_call) begin
        // Only the counter is pushed; the status word is left alone.
        depth <= depth + 4'h1;
        pc <= call_vector;
      end else if ((ret_req || plain_ret) && depth != 4'h0) begin
        depth <= depth - 4'h1;
      end
    end
  end
endmodule : vic_core_model
`default_nettype wire

//--- tb/vic_top_props.sv
// Concurrent checks on the ports of the interrupt controller.
`timescale 1ns/1ns
`default_nettype none
module vic_top_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Sources and configuration
  input wire logic [3:0] ext_pin_n,
  input wire logic [3:0] ext_edge_mode,
  input wire logic timer_zero_overflow_set,
  input wire logic [1:0] timer_flag_wr_en,
  input wire logic [1:0] timer_flag_wr_data,
  input wire logic [7:0] primary_irq_enable_reg,
  // Instruction status
  input wire logic instr_last_cycle,
  input wire logic instr_writes_irq_cfg,
  input wire logic instr_is_return_from_service,
  // Outputs watched
  input wire logic hardware_long_call,
  input wire vic_pkg::vic_vec_t call_vector,
  input wire vic_pkg::vic_src_t call_source,
  input wire vic_pkg::vic_insvc_t in_service,
  input wire logic [3:0] ext_pin_request_flag,
  input wire logic timer_zero_overflow_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_last;
    hardware_long_call |-> $past(instr_last_cycle);
  endproperty
  a_last: assert property (p_last) else $error("call off last cycle");
  property p_block;
    hardware_long_call |-> !$past(instr_writes_irq_cfg)
      && !$past(instr_is_return_from_service);
  endproperty
  a_block: assert property (p_block) else $error("call not withheld");
  property p_gate;
    hardware_long_call |-> $past(primary_irq_enable_reg[7]);
  endproperty
  a_gate: assert property (p_gate) else $error("call with gate off");
  property p_vec;
    hardware_long_call |->
      call_vector == 16'h0003 + {9'h000, call_source, 3'h0};
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector");
  property p_level;
    hardware_long_call |-> $onehot(in_service ^ $past(in_service))
      && (in_service ^ $past(in_service)) > $past(in_service);
  endproperty
  a_level: assert property (p_level) else $error("bad pre-emption");
  property p_retire;
    $past(instr_is_return_from_service) && $past(in_service) != 4'h0
      |-> $onehot(in_service ^ $past(in_service))
      && in_service < $past(in_service);
  endproperty
  a_retire: assert property (p_retire) else $error("bad retire");
  property p_pin;
    !$past(sys_rst) |-> ((ext_pin_request_flag ^ ~$past(ext_pin_n))
      & ~$past(ext_edge_mode)) == 4'h0;
  endproperty
  a_pin: assert property (p_pin) else $error("level flag off pin");
  property p_t0clr;
    hardware_long_call && call_source == 4'h1
      && !$past(timer_zero_overflow_set) && !$past(timer_flag_wr_en[0])
      |-> !timer_zero_overflow_flag;
  endproperty
  a_t0clr: assert property (p_t0clr) else $error("timer flag kept");
  property p_swset;
    !$past(sys_rst) && $past(timer_flag_wr_en[0] && timer_flag_wr_data[0])
      |-> timer_zero_overflow_flag;
  endproperty
  a_swset: assert property (p_swset) else $error("write ignored");
endmodule : vic_top_props
bind vic_top vic_top_props i_props (.*);
`default_nettype wire

//--- tb/vic_top_tb_top.sv
// Self-checking bench of the interrupt controller with a core model.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: value mismatch", $time); end end
module vic_top_tb_top;
  logic clk = 1'b0;
  logic sys_rst, timer_zero_overflow_set, timer_one_overflow_set;
  logic [3:0] ext_pin_n, ext_edge_mode, ext_flag_wr_en, ext_flag_wr_data;
  logic [1:0] timer_flag_wr_en, timer_flag_wr_data, ext_hi_irq_enable;
  logic uart_receive_complete_flag, uart_send_complete_flag;
  logic timer_two_overflow_flag, timer_two_ext_flag, serial_periph_done_flag;
  logic serial_periph_fault_flag, serial_periph_overrun_flag;
  logic wake_timer_overflow_flag, supply_drop_flag, supply_drop_reset_option;
  logic [7:0] primary_irq_enable_reg;
  logic [2:0] extended_irq_enable_reg, extended_prio_low_reg;
  logic [2:0] extended_prio_high_reg;
  logic [5:0] primary_prio_low_reg, primary_prio_high_reg;
  logic [1:0] ext_hi_prio_low, ext_hi_prio_high;
  logic instr_last_cycle, instr_writes_irq_cfg, instr_is_return_from_service;
  logic hardware_long_call, ret_req, plain_ret;
  vic_pkg::vic_vec_t call_vector, pc;
  vic_pkg::vic_src_t call_source;
  vic_pkg::vic_insvc_t in_service;
  logic [3:0] ext_pin_request_flag, depth;
  logic timer_zero_overflow_flag, timer_one_overflow_flag, wake_request;
  logic irq_request_pending;
  int n_mismatch = 0;
  int n_compared = 0;
  vic_top i_dut (.*);
  vic_core_model i_core (.*);
  always #25 clk = ~clk;
  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic expect_call(input vic_pkg::vic_src_t s,
                             input vic_pkg::vic_vec_t v);
    int i;
    i = 0;
    @(negedge clk);
    while (hardware_long_call !== 1'b1 && i < 20) begin
      @(negedge clk);
      i++;
    end
    if (hardware_long_call !== 1'b1) begin
      n_mismatch++;
      conclude();
    end
    `CHK(call_source, s)
    `CHK(call_vector, v)
  endtask : expect_call
  task automatic no_call(input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK(hardware_long_call, 1'b0)
    end
  endtask : no_call
  // Returns from service and stops once the controller has retired it.
  task automatic ret();
    @(posedge clk);
    ret_req <= 1'b1;
    @(posedge clk);
    ret_req <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : ret
  initial begin
    {timer_zero_overflow_set, timer_one_overflow_set, ext_edge_mode,
     ext_flag_wr_en, ext_flag_wr_data, timer_flag_wr_en, timer_flag_wr_data,
     ext_hi_irq_enable, uart_receive_complete_flag, uart_send_complete_flag,
     timer_two_overflow_flag, timer_two_ext_flag, serial_periph_done_flag,
     serial_periph_fault_flag, serial_periph_overrun_flag,
     wake_timer_overflow_flag, supply_drop_flag, supply_drop_reset_option,
     primary_irq_enable_reg, extended_irq_enable_reg, extended_prio_low_reg,
     extended_prio_high_reg, primary_prio_low_reg, primary_prio_high_reg,
     ext_hi_prio_low, ext_hi_prio_high, instr_last_cycle,
     instr_writes_irq_cfg, ret_req, plain_ret} <= '0;
    sys_rst <= 1'b1;
    ext_pin_n <= 4'hF;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    `CHK(in_service, 4'h0)
    `CHK(hardware_long_call, 1'b0)
    @(posedge clk);
    primary_irq_enable_reg <= 8'h02;
    instr_last_cycle <= 1'b1;
    timer_zero_overflow_set <= 1'b1;
    @(posedge clk);
    timer_zero_overflow_set <= 1'b0;
    no_call(4);
    @(posedge clk);
    primary_irq_enable_reg <= 8'h82;
    instr_last_cycle <= 1'b0;
    no_call(3);
    @(posedge clk);
    instr_last_cycle <= 1'b1;
    instr_writes_irq_cfg <= 1'b1;
    no_call(3);
    @(posedge clk);
    instr_writes_irq_cfg <= 1'b0;
    expect_call(4'h1, 16'h000B);
    `CHK(timer_zero_overflow_flag, 1'b0)
    `CHK(in_service, 4'h1)
    @(posedge clk);
    plain_ret <= 1'b1;
    @(negedge clk);
    `CHK(depth, 4'h1)
    `CHK(pc, 16'h000B)
    @(posedge clk);
    plain_ret <= 1'b0;
    no_call(2);
    `CHK(in_service, 4'h1)
    `CHK(depth, 4'h0)
    ret();
    `CHK(in_service, 4'h0)
    // A flag that drops while the call is withheld must be forgotten.
    @(posedge clk);
    primary_irq_enable_reg <= 8'h90;
    instr_last_cycle <= 1'b0;
    uart_receive_complete_flag <= 1'b1;
    @(posedge clk);
    uart_receive_complete_flag <= 1'b0;
    instr_last_cycle <= 1'b1;
    no_call(3);
    @(posedge clk);
    primary_irq_enable_reg <= 8'h80;
    extended_irq_enable_reg <= 3'h7;
    serial_periph_fault_flag <= 1'b1;
    wake_timer_overflow_flag <= 1'b1;
    supply_drop_reset_option <= 1'b1;
    supply_drop_flag <= 1'b1;
    expect_call(4'h8, 16'h0043);
    no_call(3);
    @(posedge clk);
    serial_periph_fault_flag <= 1'b0;
    ret();
    expect_call(4'h9, 16'h004B);
    `CHK(wake_request, 1'b1)
    @(posedge clk);
    wake_timer_overflow_flag <= 1'b0;
    extended_prio_high_reg <= 3'h4;
    no_call(3);
    `CHK(wake_request, 1'b0)
    @(posedge clk);
    supply_drop_reset_option <= 1'b0;
    expect_call(4'hA, 16'h0053);
    `CHK(in_service, 4'h5)
    @(posedge clk);
    supply_drop_flag <= 1'b0;
    ret();
    `CHK(in_service, 4'h1)
    ret();
    @(posedge clk);
    primary_irq_enable_reg <= 8'h84;
    ext_pin_n <= 4'hD;
    expect_call(4'h2, 16'h0013);
    ret();
    expect_call(4'h2, 16'h0013);
    @(posedge clk);
    ext_pin_n <= 4'hF;
    ret();
    @(posedge clk);
    ext_flag_wr_en <= 4'h2;
    ext_flag_wr_data <= 4'h2;
    @(posedge clk);
    ext_flag_wr_en <= 4'h0;
    @(negedge clk);
    `CHK(ext_pin_request_flag, 4'h0)
    @(posedge clk);
    ext_edge_mode <= 4'h1;
    primary_irq_enable_reg <= 8'h81;
    ext_flag_wr_en <= 4'h1;
    ext_flag_wr_data <= 4'h1;
    @(posedge clk);
    ext_flag_wr_en <= 4'h0;
    expect_call(4'h0, 16'h0003);
    `CHK(ext_pin_request_flag, 4'h0)
    ret();
    // Two timers tie at level 1; timer 0 is raised by a software write.
    @(posedge clk);
    primary_irq_enable_reg <= 8'hAA;
    primary_prio_low_reg <= 6'h28;
    instr_last_cycle <= 1'b0;
    timer_two_overflow_flag <= 1'b1;
    timer_one_overflow_set <= 1'b1;
    timer_flag_wr_en <= 2'h1;
    timer_flag_wr_data <= 2'h1;
    @(posedge clk);
    timer_one_overflow_set <= 1'b0;
    timer_flag_wr_en <= 2'h0;
    instr_last_cycle <= 1'b1;
    expect_call(4'h3, 16'h001B);
    `CHK(timer_one_overflow_flag, 1'b0)
    `CHK(timer_zero_overflow_flag, 1'b1)
    `CHK(irq_request_pending, 1'b1)
    `CHK(wake_request, 1'b0)
    `CHK(in_service, 4'h2)
    ret();
    expect_call(4'h5, 16'h002B);
    @(posedge clk);
    timer_two_overflow_flag <= 1'b0;
    timer_flag_wr_en <= 2'h1;
    timer_flag_wr_data <= 2'h0;
    @(posedge clk);
    timer_flag_wr_en <= 2'h0;
    @(negedge clk);
    `CHK(timer_zero_overflow_flag, 1'b0)
    ret();
    conclude();
  end
endmodule : vic_top_tb_top
`default_nettype wire
